// ---- olc_defines.vh ----
// constants for the oscillator lock and clock-failure recovery block
`ifndef OLC_DEFINES_VH
`define OLC_DEFINES_VH

// ==========================================================
// register offsets (byte addresses)
`define OLC_ADDR_CTL      12'h000
`define OLC_ADDR_STAT     12'h004
`define OLC_ADDR_IRQ_STAT 12'h008
`define OLC_ADDR_IRQ_CLR  12'h00C
`define OLC_ADDR_IRQ_EN   12'h010

// ==========================================================
// unlock keys
`define OLC_KEY1 8'hE7
`define OLC_KEY2 8'h18

// ==========================================================
// control register fields
`define OLC_CTL_IPO_EN  7
`define OLC_CTL_BKP_EN  6
`define OLC_CTL_PFD_EN  5
`define OLC_CTL_BFD_EN  4
`define OLC_CTL_SEL_HI  2
`define OLC_CTL_SEL_LO  0
`define OLC_CTL_RESET   8'hC0

// ==========================================================
// clock source codes
`define OLC_SEL_IPO 3'h0
`define OLC_SEL_WDT 3'h3

// ==========================================================
// lock states
`define OLC_ST_LOCKED   2'h0
`define OLC_ST_KEY1     2'h1
`define OLC_ST_UNLOCKED 2'h2

// ==========================================================
// interrupt bits
`define OLC_IRQ_PRI 0
`define OLC_IRQ_BKP 1

// ==========================================================
// register select bits
`define OLC_HIT_CTL  0
`define OLC_HIT_STAT 1
`define OLC_HIT_IST  2
`define OLC_HIT_ICLR 3
`define OLC_HIT_IEN  4

// ==========================================================
// failure threshold timing
`define OLC_CLK_PERIOD_NS 100
`define OLC_FAIL_TIME_NS  1000000
`define OLC_FAIL_CYC      (`OLC_FAIL_TIME_NS / `OLC_CLK_PERIOD_NS)

`endif

// ---- olc_osc_lock_and_fail_recovery.v ----
// oscillator control with write lock, failure detection and fail-over
// Function
// - unlock needs writes E7 then 18
// - next write updates, then relocks
// - out-of-order writes leave register unchanged
// - keys ordered, consecutive among control writes (a repeated E7 is allowed)
// - other register accesses keep lock state
// - detection may be enabled after select write
// - precision oscillator enabled out of reset
// - precision oscillator never auto disabled
// - primary failure raises clock-fail event
// - primary failure forces watchdog oscillator clock
// - processor keeps running on watchdog clock
// - fail-over only with watchdog oscillator enabled
// - no fail-over when watchdog source selected
// - fail when clock below about 1 kHz
`timescale 1ns/1ns
`include "olc_defines.vh"

module olc_osc_lock_and_fail_recovery #(
    parameter integer CW       = 16,
    parameter integer FAIL_CYC = `OLC_FAIL_CYC
) (
    input  wire        pclk,
    input  wire        presetn,
    // register bus
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output wire        pready,
    output wire        pslverr,
    output wire [31:0] prdata,
    // oscillator activity
    input  wire        primary_osc_tick,
    input  wire        backup_osc_tick,
    // clock control
    output wire        internal_precision_osc_en,
    output wire        backup_osc_en,
    output wire [2:0]  clock_source_select,
    output wire [2:0]  sys_clk_sel,
    // events
    output wire        clk_fail_event,
    output wire        irq
);

// ==========================================================
// threshold cast to counter width
localparam [CW-1:0] FAIL_LIM = FAIL_CYC[CW-1:0];

// ==========================================================
// state
reg [7:0]    clock_source_control_reg_ff;
reg [1:0]    lock_st_ff;
reg [1:0]    nxt_lock_st;

reg          failover_ff;
reg [CW-1:0] pri_cnt_ff;
reg [CW-1:0] bkp_cnt_ff;

reg [1:0]    irq_stat_ff;
reg [1:0]    irq_en_ff;
reg          fail_evt_ff;
reg [31:0]   prdata_ff;

// ==========================================================
// decode
// one-hot register select, zero for an unmapped address
function [4:0] reg_hit;
    input [11:0] addr;
    begin
        reg_hit = 5'h00;
        case (addr)
            `OLC_ADDR_CTL: begin
                reg_hit[`OLC_HIT_CTL] = 1'b1;
            end
            `OLC_ADDR_STAT: begin
                reg_hit[`OLC_HIT_STAT] = 1'b1;
            end
            `OLC_ADDR_IRQ_STAT: begin
                reg_hit[`OLC_HIT_IST] = 1'b1;
            end
            `OLC_ADDR_IRQ_CLR: begin
                reg_hit[`OLC_HIT_ICLR] = 1'b1;
            end
            `OLC_ADDR_IRQ_EN: begin
                reg_hit[`OLC_HIT_IEN] = 1'b1;
            end
            default: begin
                reg_hit = 5'h00;
            end
        endcase
    end
endfunction

wire [4:0] hit       = reg_hit(paddr);
wire       apb_wr    = psel & penable & pwrite;
wire       apb_setup = psel & ~penable;
wire       wr_ctl    = apb_wr & hit[`OLC_HIT_CTL];
wire       wr_clr    = apb_wr & hit[`OLC_HIT_ICLR];
wire       wr_en     = apb_wr & hit[`OLC_HIT_IEN];
wire [7:0] wbyte     = pwdata[7:0];
wire       mapped    = |hit;

// the update write is the one landing while unlocked
wire ctl_update = wr_ctl & (lock_st_ff == `OLC_ST_UNLOCKED);

// key bytes are matched on the low byte only
wire key1_seen = (wbyte == `OLC_KEY1);
wire key2_seen = (wbyte == `OLC_KEY2);

// ==========================================================
// control fields
wire ipo_en  = clock_source_control_reg_ff[`OLC_CTL_IPO_EN];
wire bkp_en  = clock_source_control_reg_ff[`OLC_CTL_BKP_EN];
wire pfd_en  = clock_source_control_reg_ff[`OLC_CTL_PFD_EN];
wire bfd_en  = clock_source_control_reg_ff[`OLC_CTL_BFD_EN];
wire [2:0] sel_field =
    clock_source_control_reg_ff[`OLC_CTL_SEL_HI:`OLC_CTL_SEL_LO];

// ==========================================================
// silence counter: cleared by a tick or when disabled, saturates
function [CW-1:0] silence_cnt;
    input [CW-1:0] cnt;
    input          tick;
    input          en;
    begin
        if (tick | ~en) begin
            silence_cnt = {CW{1'b0}};
        end else if (cnt == FAIL_LIM) begin
            silence_cnt = cnt;
        end else begin
            silence_cnt = cnt + {{(CW-1){1'b0}}, 1'b1};
        end
    end
endfunction

// ==========================================================
// lock state machine
always @* begin
    nxt_lock_st = lock_st_ff;
    if (wr_ctl) begin
        case (lock_st_ff)
            `OLC_ST_LOCKED: begin
                if (key1_seen) begin
                    nxt_lock_st = `OLC_ST_KEY1;
                end
            end
            `OLC_ST_KEY1: begin
                // a repeated first key keeps the sequence armed
                if (key2_seen) begin
                    nxt_lock_st = `OLC_ST_UNLOCKED;
                end else if (!key1_seen) begin
                    nxt_lock_st = `OLC_ST_LOCKED;
                end
            end
            `OLC_ST_UNLOCKED: begin
                nxt_lock_st = `OLC_ST_LOCKED;
            end
            default: begin
                nxt_lock_st = `OLC_ST_LOCKED;
            end
        endcase
    end
end

// accesses to other addresses never reach this process
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        lock_st_ff <= `OLC_ST_LOCKED;
    end else begin
        lock_st_ff <= nxt_lock_st;
    end
end

// ==========================================================
// control register
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        clock_source_control_reg_ff <= `OLC_CTL_RESET;
    end else if (ctl_update) begin
        // value stored as written: no bit changes on its own
        clock_source_control_reg_ff <= wbyte;
    end
end

// ==========================================================
// failure detection
wire pri_fail = pfd_en & (pri_cnt_ff == FAIL_LIM);
wire bkp_fail = bfd_en & (bkp_cnt_ff == FAIL_LIM);

// a select write restarts both watches so enabling right after is safe
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        pri_cnt_ff <= {CW{1'b0}};
    end else if (ctl_update) begin
        pri_cnt_ff <= {CW{1'b0}};
    end else begin
        pri_cnt_ff <= silence_cnt(pri_cnt_ff, primary_osc_tick, pfd_en);
    end
end

// backup watch mirrors the primary one
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        bkp_cnt_ff <= {CW{1'b0}};
    end else if (ctl_update) begin
        bkp_cnt_ff <= {CW{1'b0}};
    end else begin
        bkp_cnt_ff <= silence_cnt(bkp_cnt_ff, backup_osc_tick, bfd_en);
    end
end

// ==========================================================
// fail-over
wire can_failover = bkp_en & (sel_field != `OLC_SEL_WDT);
wire pri_fail_new = pri_fail & ~irq_stat_ff[`OLC_IRQ_PRI];

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        failover_ff <= 1'b0;
    end else if (ctl_update) begin
        // software recovery: a new selection ends the forced clock
        failover_ff <= 1'b0;
    end else if (pri_fail & can_failover) begin
        failover_ff <= 1'b1;
    end
end

// fail-over overrides the programmed selection
function [2:0] eff_src;
    input       forced;
    input [2:0] programmed;
    begin
        if (forced) begin
            eff_src = `OLC_SEL_WDT;
        end else begin
            eff_src = programmed;
        end
    end
endfunction

// held until software writes a new selection
assign sys_clk_sel = eff_src(failover_ff, sel_field);

// ==========================================================
// clock-fail event, one pulse per new failure
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        fail_evt_ff <= 1'b0;
    end else begin
        fail_evt_ff <= pri_fail_new;
    end
end

// ==========================================================
// interrupt status, set wins over clear
wire [1:0] irq_set = {bkp_fail, pri_fail};
wire [1:0] irq_clr = wr_clr ? pwdata[1:0] : 2'h0;

// an event in the clearing cycle survives, so no failure is lost
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        irq_stat_ff <= 2'h0;
    end else begin
        if (irq_set[`OLC_IRQ_PRI]) begin
            irq_stat_ff[`OLC_IRQ_PRI] <= 1'b1;
        end else if (irq_clr[`OLC_IRQ_PRI]) begin
            irq_stat_ff[`OLC_IRQ_PRI] <= 1'b0;
        end

        if (irq_set[`OLC_IRQ_BKP]) begin
            irq_stat_ff[`OLC_IRQ_BKP] <= 1'b1;
        end else if (irq_clr[`OLC_IRQ_BKP]) begin
            irq_stat_ff[`OLC_IRQ_BKP] <= 1'b0;
        end
    end
end

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        irq_en_ff <= 2'h0;
    end else if (wr_en) begin
        irq_en_ff <= pwdata[1:0];
    end
end

// ==========================================================
// status word
wire [31:0] stat_word = {25'h0, sys_clk_sel, failover_ff, 1'b0, lock_st_ff};

// clear register and unmapped addresses read as zero
function [31:0] rd_word;
    input [4:0]  sel_hit;
    input [7:0]  ctl_v;
    input [31:0] stat_v;
    input [1:0]  ist_v;
    input [1:0]  ien_v;
    begin
        rd_word = 32'h0;
        if (sel_hit[`OLC_HIT_CTL]) begin
            rd_word = {24'h0, ctl_v};
        end
        if (sel_hit[`OLC_HIT_STAT]) begin
            rd_word = stat_v;
        end
        if (sel_hit[`OLC_HIT_IST]) begin
            rd_word = {30'h0, ist_v};
        end
        if (sel_hit[`OLC_HIT_IEN]) begin
            rd_word = {30'h0, ien_v};
        end
    end
endfunction

// ==========================================================
// read data captured in setup phase, zero wait states
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        prdata_ff <= 32'h0;
    end else if (apb_setup & ~pwrite) begin
        prdata_ff <= rd_word(hit, clock_source_control_reg_ff, stat_word,
                             irq_stat_ff, irq_en_ff);
    end
end

// ==========================================================
// outputs
assign pready                    = 1'b1;
assign pslverr                   = psel & penable & ~mapped;
assign prdata                    = prdata_ff;
assign internal_precision_osc_en = ipo_en;
assign backup_osc_en             = bkp_en;
assign clock_source_select       = sel_field;
assign clk_fail_event            = fail_evt_ff;
assign irq                       = |(irq_stat_ff & irq_en_ff);

endmodule

// ---- olc_osc_lock_properties.sv ----
// assertion checker for the oscillator lock and fail-over block
`timescale 1ns/1ns
`include "olc_defines.vh"
module olc_osc_lock_properties #(
    parameter integer CW       = 16,
    parameter integer FAIL_CYC = 20
) (
    input wire        pclk,
    input wire        presetn,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [11:0] paddr,
    input wire        primary_osc_tick,
    input wire        internal_precision_osc_en,
    input wire        backup_osc_en,
    input wire [2:0]  clock_source_select,
    input wire [2:0]  sys_clk_sel,
    input wire        clk_fail_event
);
    // ======================================================
    // helpers
    reg        ctl_wr_ff;
    reg [15:0] quiet_ff;
    // counts silence regardless of enables, so it never lags the design
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl_wr_ff <= 1'b0;
            quiet_ff  <= 16'h0000;
        end else begin
            ctl_wr_ff <= psel && penable && pwrite && (paddr == `OLC_ADDR_CTL);
            quiet_ff  <= primary_osc_tick ? 16'h0000 : quiet_ff + 16'h0001;
        end
    end
    // ======================================================
    // properties
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    chk_event_pulse: assert property (clk_fail_event |=> !clk_fail_event)
        else $error("fail event longer than one cycle");
    chk_ipo_reset: assert property ($rose(presetn) |-> internal_precision_osc_en)
        else $error("precision osc off after reset");
    chk_ipo_kept: assert property ($fell(internal_precision_osc_en) |-> ctl_wr_ff)
        else $error("precision osc dropped without a write");
    chk_ctl_locked: assert property (!ctl_wr_ff |-> $stable(clock_source_select))
        else $error("select changed without a write");
    chk_sel_source: assert property (
        sys_clk_sel == clock_source_select || sys_clk_sel == `OLC_SEL_WDT)
        else $error("system clock source not select or backup");
    chk_fail_over: assert property (
        clk_fail_event && backup_osc_en && clock_source_select != `OLC_SEL_WDT
        |-> ##[0:1] sys_clk_sel == `OLC_SEL_WDT)
        else $error("no switch to backup osc");
    chk_needs_backup: assert property (
        !backup_osc_en |-> sys_clk_sel == clock_source_select)
        else $error("fail-over with backup osc off");
    chk_fail_quiet: assert property (clk_fail_event |-> quiet_ff >= FAIL_CYC - 2)
        else $error("failure flagged too early");
endmodule
bind olc_osc_lock_and_fail_recovery olc_osc_lock_properties #(.CW(CW), .FAIL_CYC(FAIL_CYC)) u_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .primary_osc_tick(primary_osc_tick),
    .internal_precision_osc_en(internal_precision_osc_en), .backup_osc_en(backup_osc_en),
    .clock_source_select(clock_source_select), .sys_clk_sel(sys_clk_sel),
    .clk_fail_event(clk_fail_event));

// ---- testbench.sv ----
// self-checking bench for the oscillator lock and fail-over block
`timescale 1ns/1ns
`include "olc_defines.vh"
module testbench;
    localparam integer FC = 20;
    reg         pclk, presetn, psel, penable, pwrite, pri_tick, err;
    reg  [11:0] paddr;
    reg  [31:0] pwdata, rd;
    wire        pready, pslverr, irq, ipo_en, bkp_en, evt;
    wire [31:0] prdata;
    wire [2:0]  sel, sys_sel;
    integer     n_fail, tests_run;
    olc_osc_lock_and_fail_recovery #(.CW(16), .FAIL_CYC(FC)) DUT (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
        .primary_osc_tick(pri_tick), .backup_osc_tick(1'b1), .internal_precision_osc_en(ipo_en),
        .backup_osc_en(bkp_en), .clock_source_select(sel), .sys_clk_sel(sys_sel),
        .clk_fail_event(evt), .irq(irq));
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    // ======================================================
    // shared tasks
    task conclude;
        begin
            $display("mismatches %0d of %0d checks", n_fail, tests_run);
            if (n_fail == 0 && tests_run > 0)
                $display("*** PASS ***");
            else
                $display("*** FAIL ***");
            $finish;
        end
    endtask
    task chk(input [31:0] got, input [31:0] exp);
        begin
            tests_run = tests_run + 1;
            if (got !== exp) begin
                n_fail = n_fail + 1;
                $display("Error at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask
    // holds the request until pready is seen high at an edge
    task xfer(input w, input [11:0] a, input [31:0] d);
        begin
            psel    <= 1'b1;
            penable <= 1'b0;
            pwrite  <= w;
            paddr   <= a;
            pwdata  <= d;
            @(posedge pclk);
            penable <= 1'b1;
            @(posedge pclk);
            while (pready !== 1'b1) @(posedge pclk);
            rd = prdata;
            err = pslverr;
            psel    <= 1'b0;
            penable <= 1'b0;
            @(posedge pclk);
        end
    endtask
    task rdchk(input [11:0] a, input [31:0] exp);
        begin
            xfer(1'b0, a, 32'h0);
            chk(rd, exp);
        end
    endtask
    task ctl(input [7:0] v);
        begin
            xfer(1'b1, `OLC_ADDR_CTL, {24'h0, `OLC_KEY1});
            xfer(1'b1, `OLC_ADDR_IRQ_EN, 32'h0);
            xfer(1'b1, `OLC_ADDR_CTL, {24'h0, `OLC_KEY2});
            xfer(1'b1, `OLC_ADDR_CTL, {24'h0, v});
        end
    endtask
    task idle(input integer n);
        repeat (n) @(posedge pclk);
    endtask
    // ======================================================
    // scenarios
    task t_reset;
        begin
            rdchk(`OLC_ADDR_CTL, 32'hC0);
            rdchk(`OLC_ADDR_STAT, 32'h00);
            rdchk(12'h020, 32'h00);
            chk({31'h0, err}, 32'h1);
        end
    endtask
    task t_lock;
        begin
            ctl(8'h40);
            rdchk(`OLC_ADDR_CTL, 32'h40);
            chk({31'h0, ipo_en}, 32'h0);
            rdchk(`OLC_ADDR_STAT, 32'h00);
            xfer(1'b1, `OLC_ADDR_CTL, 32'hC1);
            xfer(1'b1, `OLC_ADDR_CTL, 32'h18);
            xfer(1'b1, `OLC_ADDR_CTL, 32'hE7);
            xfer(1'b1, `OLC_ADDR_CTL, 32'hC1);
            rdchk(`OLC_ADDR_CTL, 32'h40);
            xfer(1'b1, `OLC_ADDR_CTL, 32'hE7);
            rdchk(`OLC_ADDR_STAT, 32'h01);
            xfer(1'b1, `OLC_ADDR_CTL, 32'h18);
            rdchk(`OLC_ADDR_STAT, 32'h02);
            // the pending update write relocks before the next scenario
            xfer(1'b1, `OLC_ADDR_CTL, 32'h40);
            rdchk(`OLC_ADDR_STAT, 32'h00);
        end
    endtask
    task t_fail;
        begin
            ctl(8'hE0);
            xfer(1'b1, `OLC_ADDR_IRQ_EN, 32'h1);
            pri_tick <= 1'b0;
            idle(FC - 4);
            chk({29'h0, sys_sel}, 32'h0);
            idle(5);
            @(negedge pclk);
            chk({31'h0, evt}, 32'h1);
            idle(3);
            chk({29'h0, sys_sel}, {29'h0, `OLC_SEL_WDT});
            chk({30'h0, ipo_en, irq}, 32'h3);
            rdchk(`OLC_ADDR_STAT, 32'h38);
            xfer(1'b1, `OLC_ADDR_IRQ_EN, 32'h0);
            chk({31'h0, irq}, 32'h0);
            pri_tick <= 1'b1;
            idle(2);
            xfer(1'b1, `OLC_ADDR_IRQ_CLR, 32'h1);
            rdchk(`OLC_ADDR_IRQ_STAT, 32'h0);
        end
    endtask
    task t_nofo;
        begin
            ctl(8'hE3);
            pri_tick <= 1'b0;
            idle(FC + 8);
            rdchk(`OLC_ADDR_STAT, 32'h30);
            rdchk(`OLC_ADDR_IRQ_STAT, 32'h1);
            pri_tick <= 1'b1;
            idle(2);
            xfer(1'b1, `OLC_ADDR_IRQ_CLR, 32'h1);
            ctl(8'hA0);
            pri_tick <= 1'b0;
            idle(FC + 8);
            rdchk(`OLC_ADDR_STAT, 32'h00);
        end
    endtask
    // ======================================================
    // main sequence and watchdog
    initial begin
        n_fail = 0;
        tests_run = 0;
        {psel, penable, pwrite, presetn} = 4'h0;
        {paddr, pwdata, pri_tick} = 45'h1;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset;
        t_lock;
        t_fail;
        t_nofo;
        conclude;
    end
    initial begin
        #500000;
        n_fail = n_fail + 1;
        conclude;
    end
endmodule
